// *** ssp_dev.sv ***
// device end: two-wire command register slave with fault clear and bus timeout
// Function
// - answer bus address 0x20, write byte 0x40
// - nine clocks per byte, MSB first, ack
// - data changes only while clock is low
// - master stops write after last ack
// - master nacks last read byte, then stops
// - one direction per transfer, new start
// - write 1-3 bytes, read 1-2 by code; word codes also ack further bytes and write each into the high byte
// - first byte loads pointer, next writes register
// - read: write code, repeated start, read
// - master writes pointer before every access
// - send, write byte/word, read byte/word
// - send byte acks address and code
// - send byte fault-clear code clears faults
// - repeated start right after pointer ack
// - word read: low byte first, then high
// - timeout releases bus after 35 ms idle
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_dev #(
    parameter int unsigned TIMEOUT_CYC = 32'(`SSP_TIMEOUT_CYC),
    parameter int unsigned IW          = 4
) (
    // system side
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic fault_event_i,
    output logic      fault_o,
    output logic      bus_timeout_enable_o,
    // link
    ssp_if.dev        link
);
    import ssp_pkg::*;

    localparam int unsigned NREG = 1 << IW;

    // ------------------------------------------------------------
    // system-domain fault latch
    // ------------------------------------------------------------
    logic clr_tgl;
    logic clr_m, clr_q, clr_d;
    logic fault, next_fault;
    logic rstl_m, rst_l;
    logic cfg_m, cfg_q;
    logic [7:0] cfg, next_cfg;

    always_comb begin
        // a new fault in the clearing cycle wins
        next_fault = fault_event_i | (fault & ~(clr_q ^ clr_d));
    end

    always_ff @(posedge ref_clk_i) begin
        clr_m <= clr_tgl;
        clr_q <= clr_m;
        cfg_m <= cfg[`SSP_CFG_TO_EN_BIT];
        cfg_q <= cfg_m;
        if (rst_i) begin
            clr_d <= 1'b0;
            fault <= 1'b0;
            bus_timeout_enable_o <= 1'b0;
        end else begin
            clr_d <= clr_q;
            fault <= next_fault;
            bus_timeout_enable_o <= cfg_q;
        end
    end
    assign fault_o = fault;

    // ------------------------------------------------------------
    // link domain: sampling and edge detection
    // ------------------------------------------------------------
    logic scl_m, scl_q, scl_d, sda_m, sda_q, sda_d;
    logic flt_m, flt_q;
    logic rise, fall, start_ev, stop_ev, timeout;

    assign rise     = scl_q & ~scl_d;
    assign fall     = ~scl_q & scl_d;
    assign start_ev = scl_q & scl_d & sda_d & ~sda_q;
    assign stop_ev  = scl_q & scl_d & ~sda_d & sda_q;

    always_ff @(posedge link.link_clk) begin
        rstl_m <= rst_i;
        rst_l  <= rstl_m;
        scl_m  <= link.scl;
        scl_q  <= scl_m;
        scl_d  <= scl_q;
        sda_m  <= link.sda;
        sda_q  <= sda_m;
        sda_d  <= sda_q;
        flt_m  <= fault;
        flt_q  <= flt_m;
    end

    // ------------------------------------------------------------
    // link domain: transfer engine
    // ------------------------------------------------------------
    ssp_dev_st_t st, next_st;
    logic [3:0]  bitcnt, next_bitcnt;
    logic [7:0]  sh, next_sh;
    logic [1:0]  bidx, next_bidx;
    logic        rd_dir, next_rd_dir;
    logic [7:0]  ptr, next_ptr;
    logic [15:0] regs [NREG];
    logic [15:0] next_regs [NREG];
    logic        sda_oe, next_sda_oe;
    logic        next_clr_tgl;
    logic [31:0] tcnt, next_tcnt;
    logic        is_word;
    logic [15:0] rd_word;
    logic [7:0]  rd_byte;

    assign is_word = (ptr[7:4] == `SSP_WORD_NIBBLE);
    assign rd_word = (ptr == `SSP_CODE_STATUS) ? {15'h0000, flt_q} :
                     (ptr == `SSP_CODE_CONFIG) ? {8'h00, cfg} : regs[ptr[IW-1:0]];
    // low byte first; past the register length the bus reads ones
    assign rd_byte = (bidx == 2'd1) ? rd_word[7:0] :
                     (bidx == 2'd2 && is_word) ? rd_word[15:8] : 8'hFF;
    assign timeout = cfg[`SSP_CFG_TO_EN_BIT] && (st != SSP_D_IDLE)
                     && (tcnt >= TIMEOUT_CYC - 1);

    always_comb begin
        next_st = st; next_bitcnt = bitcnt; next_sh = sh; next_bidx = bidx;
        next_rd_dir = rd_dir; next_ptr = ptr; next_cfg = cfg; next_regs = regs;
        next_sda_oe = sda_oe; next_clr_tgl = clr_tgl;
        next_tcnt = (st == SSP_D_IDLE || rise || fall || sda_q != sda_d) ? 32'd0
                                                                         : tcnt + 32'd1;
        if (stop_ev) begin
            // command alone, then stop: send byte
            if (st != SSP_D_IDLE && !rd_dir && bidx == 2'd2 && ptr == `SSP_CODE_FAULT_CLR)
                next_clr_tgl = ~clr_tgl;
            next_st = SSP_D_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_ev) begin
            next_st = SSP_D_RX; next_bitcnt = 4'd0; next_bidx = 2'd0;
            next_sda_oe = 1'b0;
        end else if (timeout) begin
            next_st = SSP_D_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            unique case (st)
                SSP_D_IDLE: next_sda_oe = 1'b0;
                SSP_D_RX: begin
                    if (rise && bitcnt < 4'd8) begin
                        next_sh = {sh[6:0], sda_q};
                        next_bitcnt = bitcnt + 4'd1;
                    end else if (fall && bitcnt == 4'd8) begin
                        next_bitcnt = 4'd0;
                        next_st = SSP_D_ACK;
                        next_sda_oe = 1'b1;
                        next_bidx = (bidx == 2'd3) ? 2'd3 : bidx + 2'd1;
                        if (bidx == 2'd0) begin
                            if (sh[7:1] == `SSP_DEV_ADDR) next_rd_dir = sh[0];
                            else begin
                                next_st = SSP_D_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end else if (bidx == 2'd1) begin
                            next_ptr = sh;
                        end else if (bidx == 2'd2) begin
                            if (ptr == `SSP_CODE_CONFIG) next_cfg = sh;
                            else next_regs[ptr[IW-1:0]][7:0] = sh;
                        end else if (bidx == 2'd3 && is_word
                                     && ptr != `SSP_CODE_FAULT_CLR) begin
                            next_regs[ptr[IW-1:0]][15:8] = sh;
                            next_bidx = 2'd3;
                        end else begin
                            // too many bytes for this code: refuse
                            next_st = SSP_D_IDLE;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                SSP_D_ACK: if (fall) begin
                    next_sda_oe = 1'b0;
                    if (rd_dir) begin
                        next_st = SSP_D_TX;
                        next_sda_oe = !rd_byte[7];
                        next_sh = {rd_byte[6:0], 1'b0};
                        next_bitcnt = 4'd0;
                    end else begin
                        next_st = SSP_D_RX;
                    end
                end
                SSP_D_TX: begin
                    if (rise) next_bitcnt = bitcnt + 4'd1;
                    else if (fall) begin
                        if (bitcnt == 4'd8) begin
                            next_sda_oe = 1'b0;
                            next_st = SSP_D_MACK;
                        end else begin
                            next_sda_oe = !sh[7];
                            next_sh = {sh[6:0], 1'b0};
                        end
                    end
                end
                SSP_D_MACK: if (rise) begin
                    if (!sda_q) begin
                        next_st = SSP_D_ACK;
                        next_bidx = (bidx == 2'd3) ? 2'd3 : bidx + 2'd1;
                    end else begin
                        next_st = SSP_D_IDLE;
                    end
                end
                default: begin
                    next_st = SSP_D_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link.link_clk) begin
        if (rst_l) begin
            st <= SSP_D_IDLE; bitcnt <= 4'd0; sh <= 8'h00; bidx <= 2'd0;
            rd_dir <= 1'b0; ptr <= 8'h00; cfg <= `SSP_CFG_RESET; sda_oe <= 1'b0;
            clr_tgl <= 1'b0; tcnt <= 32'd0;
            for (int i = 0; i < NREG; i++) regs[i] <= 16'h0000;
        end else begin
            st <= next_st; bitcnt <= next_bitcnt; sh <= next_sh; bidx <= next_bidx;
            rd_dir <= next_rd_dir; ptr <= next_ptr; cfg <= next_cfg;
            sda_oe <= next_sda_oe; clr_tgl <= next_clr_tgl; tcnt <= next_tcnt;
            regs <= next_regs;
        end
    end

    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = sda_oe;
endmodule

// *** ssp_regs.svh ***
// constants of the serial command slave port: address, command codes, timing
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// bus addressing
`define SSP_DEV_ADDR       7'h20
`define SSP_ADDR_BYTE_WR   8'h40
// command codes
`define SSP_CODE_FAULT_CLR 8'h03
`define SSP_CODE_STATUS    8'h79
`define SSP_CODE_CONFIG    8'hD1
`define SSP_WORD_NIBBLE    4'hE
// configuration register
`define SSP_CFG_TO_EN_BIT  3
`define SSP_CFG_RESET      8'h08
// bus timeout
`define SSP_TIMEOUT_MS     35
`define SSP_LINK_CLK_PS    15000
`define SSP_TIMEOUT_CYC    ((`SSP_TIMEOUT_MS * 64'd1000000000 + `SSP_LINK_CLK_PS - 1) / `SSP_LINK_CLK_PS)
// host bus clock
`define SSP_REF_CLK_KHZ    100000
`define SSP_SCL_KHZ        400
`define SSP_QUARTER_CYC    ((`SSP_REF_CLK_KHZ + 4 * `SSP_SCL_KHZ - 1) / (4 * `SSP_SCL_KHZ))

`endif

// *** ssp_pkg.sv ***
// types shared by both ends of the serial command slave port
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_OP_SEND  = 3'b000,
        SSP_OP_WBYTE = 3'b001,
        SSP_OP_WWORD = 3'b010,
        SSP_OP_RBYTE = 3'b011,
        SSP_OP_RWORD = 3'b100
    } ssp_op_t;

    typedef enum logic [2:0] {
        SSP_D_IDLE = 3'b000,
        SSP_D_RX   = 3'b001,
        SSP_D_ACK  = 3'b010,
        SSP_D_TX   = 3'b011,
        SSP_D_MACK = 3'b100
    } ssp_dev_st_t;

    typedef enum logic [2:0] {
        SSP_H_IDLE  = 3'b000,
        SSP_H_START = 3'b001,
        SSP_H_BIT   = 3'b010,
        SSP_H_STOP  = 3'b011,
        SSP_H_DONE  = 3'b100
    } ssp_host_st_t;

    typedef enum logic [1:0] {
        SSP_K_START = 2'b00,
        SSP_K_WR    = 2'b01,
        SSP_K_RD    = 2'b10,
        SSP_K_STOP  = 2'b11
    } ssp_kind_t;
endpackage

// *** ssp_if.sv ***
// two-wire link between host and device, with open-drain resolution
`timescale 1ns/1ps
interface ssp_if (
    input wire logic link_clk
);
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // pull-up when nobody drives low
    assign scl = host_scl_oe ? host_scl_o : 1'b1;
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport dev  (input link_clk, input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
endinterface

// *** ssp_host.sv ***
// bus master end: runs send/write/read transfers on request
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_host #(
    parameter int unsigned QUARTER = `SSP_QUARTER_CYC
) (
    // clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            rst_i,
    // link
    ssp_if.host                  link,
    // command port
    input  wire logic            go_i,
    input  wire ssp_pkg::ssp_op_t op_i,
    input  wire logic [7:0]      code_i,
    input  wire logic [15:0]     wdata_i,
    output logic                 busy_o,
    output logic                 done_o,
    output logic                 nack_o,
    output logic [15:0]          rdata_o
);
    import ssp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ssp_host_st_t st, next_st;
    ssp_op_t      op, next_op;
    logic [7:0]   code, next_code;
    logic [15:0]  wdata, next_wdata;
    logic [15:0]  rdata, next_rdata;
    logic [31:0]  qcnt, next_qcnt;
    logic [1:0]   q, next_q;
    logic [2:0]   step, next_step;
    logic [3:0]   bitn, next_bitn;
    logic [7:0]   sh, next_sh;
    logic         scl_oe, next_scl_oe;
    logic         sda_oe, next_sda_oe;
    logic         busy, next_busy;
    logic         done, next_done;
    logic         nack, next_nack;
    logic         sda_m, sda_q;
    logic         tick;
    logic [10:0]  cur, nxt;

    // kind, master ack-drive bit and byte of each step of a transfer
    function automatic logic [10:0] step_of(ssp_op_t o, logic [2:0] s,
                                            logic [7:0] c, logic [15:0] w);
        logic [10:0] r;
        r = {SSP_K_STOP, 1'b0, 8'h00};
        unique case (s)
            3'd0: r = {SSP_K_START, 1'b0, 8'h00};
            3'd1: r = {SSP_K_WR, 1'b0, `SSP_ADDR_BYTE_WR};
            3'd2: r = {SSP_K_WR, 1'b0, c};
            3'd3: begin
                if (o == SSP_OP_WBYTE || o == SSP_OP_WWORD)
                    r = {SSP_K_WR, 1'b0, w[7:0]};
                else if (o == SSP_OP_RBYTE || o == SSP_OP_RWORD)
                    r = {SSP_K_START, 1'b0, 8'h00};
            end
            3'd4: begin
                if (o == SSP_OP_WWORD)
                    r = {SSP_K_WR, 1'b0, w[15:8]};
                else if (o == SSP_OP_RBYTE || o == SSP_OP_RWORD)
                    r = {SSP_K_WR, 1'b0, {`SSP_DEV_ADDR, 1'b1}};
            end
            3'd5: begin
                if (o == SSP_OP_RBYTE)
                    r = {SSP_K_RD, 1'b0, 8'h00};
                else if (o == SSP_OP_RWORD)
                    r = {SSP_K_RD, 1'b1, 8'h00};
            end
            3'd6: if (o == SSP_OP_RWORD) r = {SSP_K_RD, 1'b0, 8'h00};
            default: r = {SSP_K_STOP, 1'b0, 8'h00};
        endcase
        return r;
    endfunction

    assign cur  = step_of(op, step, code, wdata);
    assign nxt  = step_of(op, step + 3'd1, code, wdata);
    assign tick = (qcnt == QUARTER - 1);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st; next_op = op; next_code = code; next_wdata = wdata;
        next_rdata = rdata; next_qcnt = tick ? 32'd0 : qcnt + 32'd1;
        next_q = q; next_step = step; next_bitn = bitn; next_sh = sh;
        next_scl_oe = scl_oe; next_sda_oe = sda_oe; next_busy = busy;
        next_done = 1'b0; next_nack = nack;
        unique case (st)
            SSP_H_IDLE: begin
                next_qcnt = 32'd0;
                if (go_i) begin
                    next_st = SSP_H_START; next_op = op_i; next_code = code_i;
                    next_wdata = wdata_i; next_step = 3'd0; next_q = 2'd0;
                    next_busy = 1'b1; next_nack = 1'b0;
                end
            end
            SSP_H_START: if (tick) begin
                next_q = q + 2'd1;
                unique case (q)
                    2'd0: next_sda_oe = 1'b0;
                    2'd1: next_scl_oe = 1'b0;
                    2'd2: next_sda_oe = 1'b1;
                    2'd3: begin
                        next_scl_oe = 1'b1; next_step = step + 3'd1;
                        next_bitn = 4'd0; next_sh = nxt[7:0];
                        next_st = (ssp_kind_t'(nxt[10:9]) == SSP_K_STOP) ? SSP_H_STOP
                                                                          : SSP_H_BIT;
                    end
                endcase
            end
            SSP_H_BIT: if (tick) begin
                next_q = q + 2'd1;
                unique case (q)
                    2'd0: begin
                        if (ssp_kind_t'(cur[10:9]) == SSP_K_WR)
                            next_sda_oe = (bitn < 4'd8) && !sh[7];
                        else
                            next_sda_oe = (bitn == 4'd8) && cur[8];
                    end
                    2'd1: next_scl_oe = 1'b0;
                    2'd2: begin
                        if (ssp_kind_t'(cur[10:9]) == SSP_K_WR && bitn == 4'd8)
                            next_nack = sda_q;
                        else if (ssp_kind_t'(cur[10:9]) == SSP_K_RD && bitn < 4'd8) begin
                            if (step == 3'd5) next_rdata[7:0] = {rdata[6:0], sda_q};
                            else next_rdata[15:8] = {rdata[14:8], sda_q};
                        end
                    end
                    2'd3: begin
                        next_scl_oe = 1'b1; next_bitn = bitn + 4'd1;
                        next_sh = {sh[6:0], 1'b0};
                        if (bitn == 4'd8) begin
                            next_step = step + 3'd1; next_bitn = 4'd0; next_sh = nxt[7:0];
                            if (nack || ssp_kind_t'(nxt[10:9]) == SSP_K_STOP)
                                next_st = SSP_H_STOP;
                            else if (ssp_kind_t'(nxt[10:9]) == SSP_K_START)
                                next_st = SSP_H_START;
                        end
                    end
                endcase
            end
            SSP_H_STOP: if (tick) begin
                next_q = q + 2'd1;
                unique case (q)
                    2'd0: next_sda_oe = 1'b1;
                    2'd1: next_scl_oe = 1'b0;
                    2'd2: next_sda_oe = 1'b0;
                    2'd3: next_st = SSP_H_DONE;
                endcase
            end
            SSP_H_DONE: begin
                next_st = SSP_H_IDLE; next_busy = 1'b0; next_done = 1'b1;
            end
            default: next_st = SSP_H_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        sda_m <= link.sda;
        sda_q <= sda_m;
        if (rst_i) begin
            st <= SSP_H_IDLE; op <= SSP_OP_SEND; code <= 8'h00; wdata <= 16'h0000;
            rdata <= 16'h0000; qcnt <= 32'd0; q <= 2'd0; step <= 3'd0; bitn <= 4'd0;
            sh <= 8'h00; scl_oe <= 1'b0; sda_oe <= 1'b0; busy <= 1'b0; done <= 1'b0;
            nack <= 1'b0;
        end else begin
            st <= next_st; op <= next_op; code <= next_code; wdata <= next_wdata;
            rdata <= next_rdata; qcnt <= next_qcnt; q <= next_q; step <= next_step;
            bitn <= next_bitn; sh <= next_sh; scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe; busy <= next_busy; done <= next_done;
            nack <= next_nack;
        end
    end

    assign link.host_scl_o  = 1'b0;
    assign link.host_sda_o  = 1'b0;
    assign link.host_scl_oe = scl_oe;
    assign link.host_sda_oe = sda_oe;
    assign busy_o  = busy;
    assign done_o  = done;
    assign nack_o  = nack;
    assign rdata_o = rdata;
endmodule

// *** ssp_asserts.sv ***
// link checker: framing, bit count, ack and drive timing on the two-wire bus
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_asserts #(
    parameter int unsigned TIMEOUT_CYC = 2000
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe
);
    logic        scl_q, sda_q, first, rd, in_fr;
    logic        next_first, next_rd, next_in_fr;
    logic [3:0]  bitn, next_bitn;
    logic [7:0]  sh, total, next_sh, next_total;
    logic [31:0] idle, next_idle;
    logic        rst_m, rst_q;
    // --------------------------------------------------------------
    // bus decode, sampled on the link clock like the device does
    // --------------------------------------------------------------
    wire start = scl && scl_q && sda_q && !sda;
    wire stop  = scl && scl_q && !sda_q && sda;
    wire rise  = scl && !scl_q;
    wire ack9  = rise && bitn == 4'h8;
    always_comb begin
        {next_first, next_rd, next_in_fr, next_bitn, next_sh, next_total} =
            {first, rd, in_fr, bitn, sh, total};
        next_idle = (scl != scl_q || sda != sda_q) ? '0 : idle + 32'h1;
        if (start) begin
            {next_first, next_rd, next_in_fr, next_bitn, next_total} = {3'b101, 4'h0, 8'h00};
        end else if (stop) begin
            next_in_fr = 1'b0;
        end else if (rise) begin
            next_total = total + 8'h01;
            next_bitn  = ack9 ? 4'h0 : bitn + 4'h1;
            next_first = ack9 ? 1'b0 : first;
            next_rd    = (ack9 && first) ? sh[0] : rd;
            next_sh    = ack9 ? sh : {sh[6:0], sda};
        end
    end
    always_ff @(posedge link_clk) begin
        // device sees reset two link edges late; keep $changed quiet until then
        {rst_m, rst_q} <= {rst_i, rst_m};
        if (rst_i) begin
            {scl_q, sda_q, first, rd, in_fr, bitn, sh, total, idle} <= {2'b11, 55'h0};
        end else begin
            {scl_q, sda_q} <= {scl, sda};
            {first, rd, in_fr, bitn, sh, total, idle} <=
                {next_first, next_rd, next_in_fr, next_bitn, next_sh, next_total, next_idle};
        end
    end
    dev_low_scl_a: assert property (@(posedge link_clk) disable iff (rst_i || rst_q)
        $changed(dev_sda_oe) |-> !scl) else $error("device data moved while clock high");
    host_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $changed(host_scl_oe) |-> $stable(host_sda_oe)) else $error("host clock and data moved");
    own_addr_ack_a: assert property (@(posedge link_clk) disable iff (rst_i)
        ack9 && first && sh[7:1] == `SSP_DEV_ADDR |-> !sda) else $error("own address not acked");
    foreign_nak_a: assert property (@(posedge link_clk) disable iff (rst_i)
        ack9 && first && sh[7:1] != `SSP_DEV_ADDR |-> sda) else $error("foreign address acked");
    nine_per_byte_a: assert property (@(posedge link_clk) disable iff (rst_i)
        stop |-> total inside {8'h13, 8'h1C, 8'h25}) else $error("stop not after whole bytes");
    restart_ptr_a: assert property (@(posedge link_clk) disable iff (rst_i)
        start && in_fr |-> total == 8'h13) else $error("repeated start not after pointer");
    write_release_a: assert property (@(posedge link_clk) disable iff (rst_i)
        rise && !rd && bitn != 4'h8 |-> !dev_sda_oe) else $error("device drove write data");
    master_ack_a: assert property (@(posedge link_clk) disable iff (rst_i)
        ack9 && rd && !first |-> !dev_sda_oe) else $error("device drove master ack slot");
    frame_only_a: assert property (@(posedge link_clk) disable iff (rst_i)
        dev_sda_oe |-> in_fr) else $error("device drove outside a frame");
    timeout_rel_a: assert property (@(posedge link_clk) disable iff (rst_i)
        idle > TIMEOUT_CYC + 32'h10 |-> !dev_sda_oe) else $error("bus held past timeout");
    word_wr_c: cover property (@(posedge link_clk) disable iff (rst_i) stop && total == 8'h25);
    restart_c: cover property (@(posedge link_clk) disable iff (rst_i) start && in_fr);
    mack_c: cover property (@(posedge link_clk) disable iff (rst_i) ack9 && rd && !first && !sda);
endmodule

// *** serial_command_slave_port_bench.sv ***
// bench: host end runs transfers against the device end over the link
`timescale 1ns/1ps
module serial_command_slave_port_bench;
    import ssp_pkg::*;
    logic        ref_clk_i, link_clk, rst_i, go_i, fault_event_i;
    logic        busy_o, done_o, nack_o, fault_o, bus_timeout_enable_o;
    ssp_op_t     op_i;
    logic [7:0]  code_i;
    logic [15:0] wdata_i, rdata_o;
    int          num_errors, checks, cyc;
    ssp_if link_if (.link_clk(link_clk));
    ssp_host #(.QUARTER(16)) ssp_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .link(link_if), .go_i(go_i), .op_i(op_i), .code_i(code_i), .wdata_i(wdata_i),
        .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
    ssp_dev #(.TIMEOUT_CYC(2000)) ssp_dev_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .fault_event_i(fault_event_i), .fault_o(fault_o),
        .bus_timeout_enable_o(bus_timeout_enable_o), .link(link_if));
    ssp_asserts #(.TIMEOUT_CYC(2000)) ssp_asserts_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .link_clk(link_clk), .scl(link_if.scl), .sda(link_if.sda),
        .host_scl_oe(link_if.host_scl_oe), .host_sda_oe(link_if.host_sda_oe),
        .dev_sda_oe(link_if.dev_sda_oe));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // phase offset keeps the link clock unrelated to the reference
    initial begin
        link_clk = 1'b0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic xfer(input ssp_op_t op, input logic [7:0] code, input logic [15:0] wd);
        int n;
        @(posedge ref_clk_i);
        go_i <= 1'b1;
        op_i <= op;
        code_i <= code;
        wdata_i <= wd;
        @(posedge ref_clk_i);
        go_i <= 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 8000);
        chk({15'h0000, done_o}, 16'h0001);
        chk({15'h0000, busy_o}, 16'h0000);
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_word;
        xfer(SSP_OP_WWORD, 8'hE5, 16'hA55A);
        chk({15'h0000, nack_o}, 16'h0000);
        xfer(SSP_OP_RWORD, 8'hE5, 16'h0000);
        chk(rdata_o, 16'hA55A);
        $display("word test done");
    endtask
    task automatic t_byte;
        xfer(SSP_OP_WBYTE, 8'h12, 16'h003C);
        xfer(SSP_OP_RBYTE, 8'h12, 16'h0000);
        chk({8'h00, rdata_o[7:0]}, 16'h003C);
        xfer(SSP_OP_RWORD, 8'h12, 16'h0000);
        chk(rdata_o, 16'hFF3C);
        xfer(SSP_OP_WWORD, 8'h12, 16'h7700);
        chk({15'h0000, nack_o}, 16'h0001);
        xfer(SSP_OP_RBYTE, 8'h12, 16'h0000);
        chk({8'h00, rdata_o[7:0]}, 16'h0000);
        $display("byte test done");
    endtask
    task automatic t_fault;
        @(posedge ref_clk_i);
        fault_event_i <= 1'b1;
        @(posedge ref_clk_i);
        fault_event_i <= 1'b0;
        pause(4);
        chk({15'h0000, fault_o}, 16'h0001);
        xfer(SSP_OP_RBYTE, 8'h79, 16'h0000);
        chk({15'h0000, rdata_o[0]}, 16'h0001);
        xfer(SSP_OP_SEND, 8'h03, 16'h0000);
        chk({15'h0000, nack_o}, 16'h0000);
        pause(10);
        chk({15'h0000, fault_o}, 16'h0000);
        $display("fault test done");
    endtask
    task automatic t_cfg;
        chk({15'h0000, bus_timeout_enable_o}, 16'h0001);
        xfer(SSP_OP_WBYTE, 8'hD1, 16'h0000);
        pause(10);
        chk({15'h0000, bus_timeout_enable_o}, 16'h0000);
        xfer(SSP_OP_WBYTE, 8'hD1, 16'h0008);
        pause(10);
        chk({15'h0000, bus_timeout_enable_o}, 16'h0001);
        $display("config test done");
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        rst_i = 1'b1;
        go_i = 1'b0;
        op_i = SSP_OP_SEND;
        code_i = 8'h00;
        wdata_i = 16'h0000;
        fault_event_i = 1'b0;
        num_errors = 0;
        checks = 0;
        cyc = 0;
        pause(6);
        rst_i <= 1'b0;
        pause(10);
        chk(rdata_o, 16'h0000);
        t_cfg();
        t_word();
        t_byte();
        t_fault();
        print_verdict();
    end
endmodule
